// ==== pkg/sram_host_pkg.sv ====
package sram_host_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int DEPTH = 8192;
    // ****************************************
    // Timing, figures in ns at a 10 ns clock
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 85;         // Read access, slowest grade
    localparam int WRITE_PULSE_NS = 65;    // Select to end of write
    localparam int DATA_SETUP_NS = 35;     // Data valid to end of write
    localparam int BUS_RELEASE_NS = 35;    // Select inactive to output high Z
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC = (BUS_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_RECOVER = 5'b10000
    } seq_state_t;
endpackage

// ==== logic/cycle_timer.sv ====
`timescale 1ns/1ps
// ****************************************
// Down counter for phase lengths
// ****************************************
module cycle_timer
    import sram_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [sram_host_pkg::CNT_W-1:0] load_value,
    output logic done
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } timer_state_t;
    timer_state_t s_q;
    timer_state_t s_d;

    // Load wins over counting
    always_comb
    begin
        s_d = s_q;
        if (load)
        begin
            s_d.count = load_value;
        end
        else if (s_q.count != CNT_ZERO)
        begin
            s_d.count = s_q.count - CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Done also while idle, so a fresh load is needed each phase
    assign done = (s_q.count == CNT_ONE) || (s_q.count == CNT_ZERO);
endmodule // cycle_timer

// ==== logic/sram_host.sv ====
`timescale 1ns/1ps
// Function
// - Host meets setup and hold around the last-falling, first-rising strobe.
// - Host keeps select or strobe high while any address line changes.
// - Host keeps write strobe high throughout every read.
// - In select-controlled reads, address is valid before select falls.
// - Host times address from last valid line to first changing line.
// - Read: select low, high select high, strobe high; data within access.
module sram_host
    import sram_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
    input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
    output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    output logic select_low_n,
    output logic select_high,
    output logic write_n,
    output logic output_gate_n,
    output logic [sram_host_pkg::DATA_W-1:0] data_pin_out,
    output logic data_pin_oe_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] data_pin_in
);
    import sram_host_pkg::*;

    typedef struct packed {
        seq_state_t state;
        logic is_write;
        logic ready;
        logic rsp;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic sel_n;
        logic sel_hi;
        logic we_n;
        logic oe_n;
        logic [DATA_W-1:0] wdata;
        logic drive_n;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } host_state_t;

    host_state_t s_q;
    host_state_t s_d;
    logic t_load;
    logic [CNT_W-1:0] t_value;
    logic t_done;

    // ****************************************
    // Phase timer
    // ****************************************
    cycle_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(t_load),
        .load_value(t_value),
        .done(t_done)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    // Address and data change only in idle, with select high; read data is
    // sampled through two flops so the capture lags the bus by two cycles.
    always_comb
    begin
        s_d = s_q;
        t_load = 1'b0;
        t_value = CNT_ZERO;
        s_d.rsp = 1'b0;
        s_d.sync1 = data_pin_in;
        s_d.sync2 = s_q.sync1;
        case (s_q.state)
            ST_IDLE:
            begin
                s_d.ready = 1'b1;
                if (req_valid && s_q.ready)
                begin
                    s_d.addr = req_addr;
                    s_d.wdata = req_wdata;
                    s_d.is_write = req_write;
                    s_d.ready = 1'b0;
                    s_d.we_n = 1'b1;
                    s_d.state = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                s_d.sel_n = 1'b0;
                s_d.sel_hi = 1'b1;
                t_load = 1'b1;
                if (s_q.is_write)
                begin
                    s_d.we_n = 1'b0;
                    s_d.drive_n = 1'b0;
                    s_d.oe_n = 1'b1;
                    t_value = CNT_W'(WRITE_CYC > SETUP_CYC ? WRITE_CYC : SETUP_CYC);
                end
                else
                begin
                    s_d.oe_n = 1'b0;
                    s_d.drive_n = 1'b1;
                    t_value = CNT_W'(ACCESS_CYC + 2);
                end
                s_d.state = ST_STROBE;
            end
            ST_STROBE:
            begin
                if (t_done)
                begin
                    s_d.sel_n = 1'b1;
                    s_d.sel_hi = 1'b0;
                    s_d.oe_n = 1'b1;
                    if (!s_q.is_write)
                    begin
                        s_d.rdata = s_q.sync2;
                        s_d.rsp = 1'b1;
                    end
                    s_d.state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                s_d.we_n = 1'b1;
                s_d.drive_n = 1'b1;
                t_load = 1'b1;
                t_value = CNT_W'(RELEASE_CYC);
                s_d.state = ST_RECOVER;
            end
            ST_RECOVER:
            begin
                if (t_done)
                begin
                    s_d.ready = 1'b1;
                    s_d.state = ST_IDLE;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.sel_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.oe_n <= 1'b1;
            s_q.drive_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Straight from flops
    assign req_ready = s_q.ready;
    assign rsp_valid = s_q.rsp;
    assign rsp_rdata = s_q.rdata;
    assign mem_addr = s_q.addr;
    assign select_low_n = s_q.sel_n;
    assign select_high = s_q.sel_hi;
    assign write_n = s_q.we_n;
    assign output_gate_n = s_q.oe_n;
    assign data_pin_out = s_q.wdata;
    assign data_pin_oe_n = s_q.drive_n;
endmodule // sram_host

// ==== dv/sram_host_checker.sv ====
`timescale 1ns/1ps
module sram_host_checker
    import sram_host_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rsp_valid,
    input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic write_n,
    input wire logic output_gate_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] data_pin_out,
    input wire logic data_pin_oe_n
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    property p_pair; select_high == !select_low_n; endproperty
    a_pair: assert property (p_pair) else $error("selects disagree");
    property p_addr_move; !$stable(mem_addr) |-> select_low_n || write_n; endproperty
    a_addr_move: assert property (p_addr_move) else $error("address moved in write");
    property p_addr_hold; !select_low_n |-> $stable(mem_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved while selected");
    property p_rd; !output_gate_n |-> write_n && data_pin_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("strobe or drive in read");
    property p_wr_start; $fell(write_n) |-> $fell(select_low_n); endproperty
    a_wr_start: assert property (p_wr_start) else $error("strobe not with select");
    property p_wr_end; $rose(select_low_n) && !write_n |=> write_n; endproperty
    a_wr_end: assert property (p_wr_end) else $error("strobe not after select");
    property p_wr_len; $fell(write_n) |-> (!select_low_n && !write_n)[*7]; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse short");
    property p_wdata; !write_n |-> !data_pin_oe_n && ($fell(write_n) || $stable(data_pin_out)); endproperty
    a_wdata: assert property (p_wdata) else $error("write data moved");
    property p_rd_lat; $fell(output_gate_n) |-> ##11 rsp_valid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule // sram_host_checker

// ==== dv/sram_model.sv ====
`timescale 1ns/1ps
module sram_model
    import sram_host_pkg::*;
#(
    parameter int SLEEP_NS = 85,
    parameter int ACC_NS = 85
)
(
    input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic write_n,
    input wire logic output_gate_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] data_pin_out,
    input wire logic data_pin_oe_n,
    output logic [sram_host_pkg::DATA_W-1:0] data_pin_in
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic awake = 1'b0;
    wire rd_late;
    wire sel = !select_low_n && select_high;
    wire wr = sel && !write_n;
    wire rd = sel && write_n && !output_gate_n;
    assign #ACC_NS rd_late = rd;
    initial data_pin_in = 8'h5a;
    // Released bus flips, never holds
    always @(rd, rd_late, mem_addr)
        data_pin_in = (rd && rd_late) ? mem[mem_addr] : ~data_pin_in;
    always @(negedge wr)
        if (!data_pin_oe_n) mem[mem_addr] = data_pin_out;
    always @(negedge select_low_n, negedge write_n, mem_addr, data_pin_out)
        if (sel) awake <= 1'b1;
    always @(posedge awake) awake <= #SLEEP_NS 1'b0;
endmodule // sram_model

// ==== dv/sram_host_tb.sv ====
`timescale 1ns/1ps
module sram_host_tb;
    import sram_host_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = 13'h0000;
    logic [DATA_W-1:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, select_low_n, select_high, write_n, output_gate_n, data_pin_oe_n;
    logic [DATA_W-1:0] rsp_rdata, data_pin_out, data_pin_in;
    logic [ADDR_W-1:0] mem_addr;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    sram_host sram_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .select_low_n(select_low_n), .select_high(select_high),
        .write_n(write_n), .output_gate_n(output_gate_n), .data_pin_out(data_pin_out),
        .data_pin_oe_n(data_pin_oe_n), .data_pin_in(data_pin_in));
    sram_model sram_model_i (.mem_addr(mem_addr), .select_low_n(select_low_n), .select_high(select_high),
        .write_n(write_n), .output_gate_n(output_gate_n), .data_pin_out(data_pin_out),
        .data_pin_oe_n(data_pin_oe_n), .data_pin_in(data_pin_in));
    task automatic end_sim();
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog, runs need under 200 cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // Request held until taken; read waits bounded
    task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do @(negedge sys_clk); while (req_ready !== 1'b1);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
        repeat (40) if (!w && rsp_valid !== 1'b1) @(negedge sys_clk);
        if (!w) chk("rsp_valid", 8'h01, {7'h00, rsp_valid});
        if (!w) chk("rdata", d, rsp_rdata);
        // Hand back on a rising edge so the next request is driven there
        if (!w) @(posedge sys_clk);
    endtask
    task automatic t_idle();
        chk("idle", 8'h17, {2'b00, req_ready, select_low_n, select_high, write_n, output_gate_n, data_pin_oe_n});
    endtask
    // Corner and alternating-bit addresses; data includes all-zero and all-one
    task automatic t_table();
        logic [ADDR_W-1:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        logic [DATA_W-1:0] d [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
        foreach (a[i]) op(1'b1, a[i], d[i]);
        foreach (a[i]) op(1'b0, a[i], d[i]);
    endtask
    // Request while busy must be dropped
    task automatic t_refuse();
        op(1'b1, 13'h0123, 8'h3c);
        req_valid <= 1'b1;
        req_wdata <= 8'hc3;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk);
        op(1'b0, 13'h0123, 8'h3c);
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        t_idle();
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_table();
        t_refuse();
        end_sim();
    end
endmodule // sram_host_tb
bind sram_host sram_host_checker sram_host_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
    .mem_addr(mem_addr), .select_low_n(select_low_n), .select_high(select_high), .write_n(write_n),
    .output_gate_n(output_gate_n), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n));
